// file: rtl/dma4_core.sv
`timescale 1ns/1ps
// How it works
// - Peripheral-to-memory drives io read and memory write strobes together.
// - Memory-to-peripheral drives memory read and io write strobes together.
// - Verify sequences addresses and end of process with all read and write strobes idle.
// - Command bit 0 set turns channels 0 and 1 into a memory pair.
// - Channel 0 gives source, channel 1 destination and the word count.
// - Software request on channel 0 starts a memory-to-memory move.
// - Channel 0 address hold rereads one source location every transfer.
// - No channel acknowledge is active during memory-to-memory moves.
// - External end of process stops a memory-to-memory service.
// - Autoinitialize restores current address and count from base copies.
// - Processor writes load base and current together; base never read.
// - Autoinitialize channels are not masked by end of process.
// - Fixed priority: channel 0 highest down to channel 3 lowest.
// - Rotating priority puts the last serviced channel lowest.
// - Winner chosen on hold acknowledge rise; hold dropped between services.
// - A running service is never preempted by a higher request.
// - Compressed timing skips the read extension state: two clocks each.
// - Upper address state puts bits 15..8 on data with strobe and enable.
// - Upper address state repeats on carry or borrow out of bit 7; pair moves run it for every read and write.
// - Current address steps after each transfer; accessed as two bytes.
// - Count holds length minus one; terminal count when it passes zero.
// - After internal end of process the count reads all ones unless autoinitialize reloads it.
// - Byte pointer picks low then high byte, toggles, cleared by command.
module dma4_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign o_in_ready = cnt_q != FULL;
	assign o_out_valid = cnt_q != '0;
	assign o_out_data = mem[rp_q];
	assign push = i_in_valid && o_in_ready;
	assign pop = i_out_ready && o_out_valid;

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wp_q] <= i_in_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : dma4_fifo

module dma4_core (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_reg_cs,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic [3:0] i_channel_request,
	input wire logic i_hold_acknowledge,
	input wire logic i_end_of_process_n,
	input wire logic [7:0] i_data,
	output logic o_hold_request,
	output logic [3:0] o_channel_acknowledge,
	output logic [7:0] o_addr_lo,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_upper_address_strobe,
	output logic o_address_output_enable,
	output logic o_io_read_strobe,
	output logic o_io_write_strobe,
	output logic o_memory_read_strobe,
	output logic o_memory_write_strobe,
	output logic o_terminal_count
);
	dma4_pkg::dma4_state_t st_q, st_d;
	logic [15:0] cur_addr_q [dma4_pkg::NCH];
	logic [15:0] cur_cnt_q [dma4_pkg::NCH];
	logic [15:0] base_addr_q [dma4_pkg::NCH];
	logic [15:0] base_cnt_q [dma4_pkg::NCH];
	logic [5:0] mode_q [dma4_pkg::NCH];
	logic [7:0] cmd_q;
	logic [3:0] mask_q;
	logic [3:0] sreq_q;
	logic [3:0] tc_stat_q;
	logic [7:0] temp_q;
	logic ptr_q;
	logic [1:0] ch_q, ch_d, top_q, win;
	logic m2m_q, m2m_d;
	logic tc_q, fin_q, hold_acknowledge_prev_q;
	logic [dma4_pkg::NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
	logic [3:0] channel_request_f, req_v;
	logic hold_acknowledge_f, eop_f, hold_acknowledge_rise;
	logic [1:0] uch, och, xtype, xmode;
	logic [15:0] ua, un, cnt_now;
	logic dec, tc, done, hi_chg, step;
	logic wr_en, rd_en, chreg;
	logic f_in_ready, f_out_valid;
	logic [7:0] f_out_data;

	function automatic logic [1:0] pick(input logic [3:0] r,
		input logic [1:0] top);
		logic [1:0] c;
		logic [1:0] w;
		logic f;
		w = top;
		f = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			c = top + 2'(i);
			if (r[c] && !f)
			begin
				w = c;
				f = 1'b1;
			end
		end
		return w;
	endfunction : pick

	// Pins come from other logic; second and third stage must agree
	assign pin_raw = {i_hold_acknowledge, ~i_end_of_process_n,
		i_channel_request};
	for (genvar g = 0; g < dma4_pkg::NPIN; g++)
	begin : g_sync
		always_ff @(posedge i_clk)
		begin
			if (i_srst)
			begin
				s1_q[g] <= 1'b0;
				s2_q[g] <= 1'b0;
				s3_q[g] <= 1'b0;
				pin_q[g] <= 1'b0;
			end
			else
			begin
				s1_q[g] <= pin_raw[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
				if (s2_q[g] == s3_q[g])
					pin_q[g] <= s3_q[g];
			end
		end
	end
	assign channel_request_f = pin_q[3:0];
	assign eop_f = pin_q[4];
	assign hold_acknowledge_f = pin_q[5];
	assign hold_acknowledge_rise = hold_acknowledge_f && !hold_acknowledge_prev_q;

	assign wr_en = i_reg_cs && i_reg_wr && st_q == dma4_pkg::ST_IDLE;
	assign rd_en = i_reg_cs && i_reg_rd && st_q == dma4_pkg::ST_IDLE;
	assign chreg = !i_reg_addr[3];

	// Pair mode: channel 1 is no peripheral, channel 0 starts by software
	always_comb
	begin
		req_v = (channel_request_f & ~mask_q) | sreq_q;
		if (cmd_q[dma4_pkg::CMD_M2M])
		begin
			req_v[1] = 1'b0;
			req_v[0] = sreq_q[0];
		end
	end
	// Fixed order must hold at once, not after the next service ends
	assign win = pick(req_v, cmd_q[dma4_pkg::CMD_ROTATE] ? top_q :
		2'd0);

	// Channel being stepped; pair mode reads ch0 and writes ch1
	assign uch = (m2m_q && (st_q == dma4_pkg::ST_MW)) ? 2'd1 :
		(m2m_q ? 2'd0 : ch_q);
	assign ua = cur_addr_q[uch];
	assign dec = mode_q[uch][dma4_pkg::MD_DEC];
	assign un = dec ? ua - 16'h0001 : ua + 16'h0001;
	assign hi_chg = un[15:8] != ua[15:8];
	assign cnt_now = cur_cnt_q[m2m_q ? 2'd1 : ch_q];
	assign tc = cnt_now == 16'h0000;
	assign xtype = mode_q[ch_q][dma4_pkg::MD_TYPE +: 2];
	assign xmode = mode_q[ch_q][dma4_pkg::MD_MODE +: 2];
	assign step = st_q == dma4_pkg::ST_S4 || st_q == dma4_pkg::ST_MW;
	assign done = tc || eop_f || (!m2m_q && xmode == dma4_pkg::MO_SINGLE)
		|| (!m2m_q && xmode == dma4_pkg::MO_DEMAND && !channel_request_f[ch_q]);

	always_comb
	begin
		st_d = st_q;
		ch_d = ch_q;
		m2m_d = m2m_q;
		unique case (st_q)
			dma4_pkg::ST_IDLE:
				if (|req_v && !cmd_q[dma4_pkg::CMD_DISABLE])
					st_d = dma4_pkg::ST_S0;
			dma4_pkg::ST_S0:
				if (hold_acknowledge_rise)
				begin
					ch_d = win;
					m2m_d = cmd_q[dma4_pkg::CMD_M2M] && win == 2'd0;
					if (!(|req_v))
						st_d = dma4_pkg::ST_END;
					else if (m2m_d)
						st_d = dma4_pkg::ST_M1;
					else
						st_d = dma4_pkg::ST_S1;
				end
			dma4_pkg::ST_S1:
				st_d = dma4_pkg::ST_S2;
			dma4_pkg::ST_S2:
				st_d = cmd_q[dma4_pkg::CMD_COMPRESS] ? dma4_pkg::ST_S4 :
					dma4_pkg::ST_S3;
			dma4_pkg::ST_S3:
				st_d = dma4_pkg::ST_S4;
			dma4_pkg::ST_S4:
				if (done)
					st_d = dma4_pkg::ST_END;
				else
					st_d = hi_chg ? dma4_pkg::ST_S1 :
						dma4_pkg::ST_S2;
			dma4_pkg::ST_M1:
				if (f_in_ready)
					st_d = dma4_pkg::ST_MR;
			dma4_pkg::ST_MR:
				st_d = dma4_pkg::ST_M2;
			dma4_pkg::ST_M2:
				if (f_out_valid)
					st_d = dma4_pkg::ST_MW;
			dma4_pkg::ST_MW:
				st_d = done ? dma4_pkg::ST_END : dma4_pkg::ST_M1;
			dma4_pkg::ST_END:
			begin
				st_d = dma4_pkg::ST_IDLE;
				m2m_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			st_q <= dma4_pkg::ST_IDLE;
			ch_q <= 2'd0;
			m2m_q <= 1'b0;
			hold_acknowledge_prev_q <= 1'b0;
			tc_q <= 1'b0;
			fin_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			ch_q <= ch_d;
			m2m_q <= m2m_d;
			hold_acknowledge_prev_q <= hold_acknowledge_f;
			if (st_q == dma4_pkg::ST_S0)
			begin
				tc_q <= 1'b0;
				fin_q <= 1'b0;
			end
			else if (step && done)
			begin
				tc_q <= tc;
				fin_q <= tc || eop_f;
			end
		end
	end

	// Address and count registers
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < dma4_pkg::NCH; i++)
			begin
				cur_addr_q[i] <= dma4_pkg::REG_RST;
				cur_cnt_q[i] <= dma4_pkg::REG_RST;
				base_addr_q[i] <= dma4_pkg::REG_RST;
				base_cnt_q[i] <= dma4_pkg::REG_RST;
			end
		end
		else if (wr_en && chreg)
		begin
			if (!i_reg_addr[0])
			begin
				cur_addr_q[i_reg_addr[2:1]][ptr_q*8 +: 8] <= i_reg_wdata;
				base_addr_q[i_reg_addr[2:1]][ptr_q*8 +: 8] <= i_reg_wdata;
			end
			else
			begin
				cur_cnt_q[i_reg_addr[2:1]][ptr_q*8 +: 8] <= i_reg_wdata;
				base_cnt_q[i_reg_addr[2:1]][ptr_q*8 +: 8] <= i_reg_wdata;
			end
		end
		else if (st_q == dma4_pkg::ST_MR)
		begin
			if (!cmd_q[dma4_pkg::CMD_HOLD0])
				cur_addr_q[0] <= un;
		end
		else if (step)
		begin
			cur_addr_q[uch] <= un;
			// Wraps to all ones on terminal count
			cur_cnt_q[m2m_q ? 2'd1 : ch_q] <= cnt_now - 16'h0001;
		end
		else if (st_q == dma4_pkg::ST_END && fin_q)
		begin
			for (int i = 0; i < dma4_pkg::NCH; i++)
				if (mode_q[i][dma4_pkg::MD_AUTO] && (i == int'(ch_q)
					|| (m2m_q && i < 2)))
				begin
					cur_addr_q[i] <= base_addr_q[i];
					cur_cnt_q[i] <= base_cnt_q[i];
				end
		end
	end

	// Command, mode, mask, request, status, pointer, priority
	always_ff @(posedge i_clk)
	begin
		if (i_srst || (wr_en && i_reg_addr == dma4_pkg::A_TEMP_CLR))
		begin
			cmd_q <= dma4_pkg::CMD_RST;
			mask_q <= dma4_pkg::MASK_RST;
			sreq_q <= 4'h0;
			tc_stat_q <= 4'h0;
			ptr_q <= 1'b0;
			top_q <= 2'd0;
			for (int i = 0; i < dma4_pkg::NCH; i++)
				mode_q[i] <= 6'h00;
		end
		else
		begin
			if ((wr_en || rd_en) && chreg)
				ptr_q <= ~ptr_q;
			if (wr_en)
			begin
				unique case (i_reg_addr)
					dma4_pkg::A_STATUS:
						cmd_q <= i_reg_wdata;
					dma4_pkg::A_REQUEST:
						sreq_q[i_reg_wdata[1:0]] <= i_reg_wdata[2];
					dma4_pkg::A_MASK_ONE:
						mask_q[i_reg_wdata[1:0]] <= i_reg_wdata[2];
					dma4_pkg::A_MODE:
						mode_q[i_reg_wdata[1:0]] <= i_reg_wdata[7:2];
					dma4_pkg::A_CLR_PTR:
						ptr_q <= 1'b0;
					dma4_pkg::A_MASK_ALL:
						mask_q <= i_reg_wdata[3:0];
					default:
						;
				endcase
			end
			// Hardware set beats the read clear
			if (st_q == dma4_pkg::ST_END && tc_q)
				tc_stat_q[ch_q] <= 1'b1;
			else if (rd_en && i_reg_addr == dma4_pkg::A_STATUS)
				tc_stat_q <= 4'h0;
			if (st_q == dma4_pkg::ST_END)
			begin
				top_q <= cmd_q[dma4_pkg::CMD_ROTATE] ? ch_q + 2'd1 :
					2'd0;
				if (fin_q)
				begin
					sreq_q[ch_q] <= 1'b0;
					if (!mode_q[ch_q][dma4_pkg::MD_AUTO])
						mask_q[ch_q] <= 1'b1;
					if (m2m_q && !mode_q[1][dma4_pkg::MD_AUTO])
						mask_q[1] <= 1'b1;
				end
			end
		end
	end

	// Pair mode byte path; read half stalls while the buffer is full
	dma4_fifo #(
		.W(dma4_pkg::FIFO_W),
		.D(dma4_pkg::FIFO_D)
	) u_fifo (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_in_valid(st_q == dma4_pkg::ST_MR),
		.o_in_ready(f_in_ready),
		.i_in_data(i_data),
		.o_out_valid(f_out_valid),
		.i_out_ready(st_q == dma4_pkg::ST_MW),
		.o_out_data(f_out_data)
	);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			temp_q <= 8'h00;
		else if (st_q == dma4_pkg::ST_MW)
			temp_q <= f_out_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_reg_rdata <= 8'h00;
		else if (rd_en)
		begin
			if (chreg)
				o_reg_rdata <= i_reg_addr[0] ?
					cur_cnt_q[i_reg_addr[2:1]][ptr_q*8 +: 8] :
					cur_addr_q[i_reg_addr[2:1]][ptr_q*8 +: 8];
			else if (i_reg_addr == dma4_pkg::A_STATUS)
				o_reg_rdata <= {channel_request_f | sreq_q, tc_stat_q};
			else if (i_reg_addr == dma4_pkg::A_TEMP_CLR)
				o_reg_rdata <= temp_q;
			else
				o_reg_rdata <= 8'h00;
		end
	end

	// Pins registered from the coming state
	always_comb
	begin
		och = m2m_d ? ((st_d == dma4_pkg::ST_M2 || st_d == dma4_pkg::ST_MW)
			? 2'd1 : 2'd0) : ch_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_hold_request <= 1'b0;
			o_channel_acknowledge <= 4'h0;
			o_addr_lo <= 8'h00;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
			o_upper_address_strobe <= 1'b0;
			o_address_output_enable <= 1'b0;
			o_io_read_strobe <= 1'b0;
			o_io_write_strobe <= 1'b0;
			o_memory_read_strobe <= 1'b0;
			o_memory_write_strobe <= 1'b0;
			o_terminal_count <= 1'b0;
		end
		else
		begin
			// Dropped in the closing state so the bus returns between services
			o_hold_request <= st_d != dma4_pkg::ST_IDLE &&
				st_d != dma4_pkg::ST_END;
			o_address_output_enable <= st_d inside {dma4_pkg::ST_S1,
				dma4_pkg::ST_S2, dma4_pkg::ST_S3, dma4_pkg::ST_S4,
				dma4_pkg::ST_M1, dma4_pkg::ST_MR, dma4_pkg::ST_M2,
				dma4_pkg::ST_MW};
			o_upper_address_strobe <= st_d inside {dma4_pkg::ST_S1,
				dma4_pkg::ST_M1, dma4_pkg::ST_M2};
			o_addr_lo <= (step && och == uch) ? un[7:0] :
				cur_addr_q[och][7:0];
			if (st_d inside {dma4_pkg::ST_S1, dma4_pkg::ST_M1,
				dma4_pkg::ST_M2})
			begin
				o_data <= (step && och == uch) ? un[15:8] :
					cur_addr_q[och][15:8];
				o_data_oe <= 1'b1;
			end
			else if (st_d == dma4_pkg::ST_MW)
			begin
				o_data <= f_out_data;
				o_data_oe <= 1'b1;
			end
			else
				o_data_oe <= 1'b0;
			o_channel_acknowledge <= 4'h0;
			if (!m2m_d && st_d inside {dma4_pkg::ST_S1, dma4_pkg::ST_S2,
				dma4_pkg::ST_S3, dma4_pkg::ST_S4})
				o_channel_acknowledge[ch_d] <= 1'b1;
			// Verify leaves every read and write strobe idle
			o_io_read_strobe <= !m2m_d && xtype == dma4_pkg::XF_WRITE &&
				st_d inside {dma4_pkg::ST_S3, dma4_pkg::ST_S4};
			o_memory_write_strobe <= st_d == dma4_pkg::ST_MW ||
				(!m2m_d && xtype == dma4_pkg::XF_WRITE &&
				st_d == dma4_pkg::ST_S4);
			o_memory_read_strobe <= st_d == dma4_pkg::ST_MR ||
				(!m2m_d && xtype == dma4_pkg::XF_READ &&
				st_d inside {dma4_pkg::ST_S3, dma4_pkg::ST_S4});
			o_io_write_strobe <= !m2m_d && xtype == dma4_pkg::XF_READ &&
				st_d == dma4_pkg::ST_S4;
			o_terminal_count <= step && tc;
		end
	end
endmodule : dma4_core

// file: rtl/dma4_pkg.sv
package dma4_pkg;
	localparam int NCH = 4;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 32;
	localparam int NPIN = 6;
	localparam logic [3:0] A_STATUS = 4'h8;
	localparam logic [3:0] A_REQUEST = 4'h9;
	localparam logic [3:0] A_MASK_ONE = 4'hA;
	localparam logic [3:0] A_MODE = 4'hB;
	localparam logic [3:0] A_CLR_PTR = 4'hC;
	localparam logic [3:0] A_TEMP_CLR = 4'hD;
	localparam logic [3:0] A_MASK_ALL = 4'hF;
	localparam int CMD_M2M = 0;
	localparam int CMD_HOLD0 = 1;
	localparam int CMD_DISABLE = 2;
	localparam int CMD_COMPRESS = 3;
	localparam int CMD_ROTATE = 4;
	localparam int MD_TYPE = 0;
	localparam int MD_AUTO = 2;
	localparam int MD_DEC = 3;
	localparam int MD_MODE = 4;
	localparam logic [1:0] XF_VERIFY = 2'h0;
	localparam logic [1:0] XF_WRITE = 2'h1;
	localparam logic [1:0] XF_READ = 2'h2;
	localparam logic [1:0] MO_DEMAND = 2'h0;
	localparam logic [1:0] MO_SINGLE = 2'h1;
	localparam logic [1:0] MO_BLOCK = 2'h2;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'hF;
	localparam logic [15:0] REG_RST = 16'h0000;
	typedef enum logic [3:0] {
		ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4,
		ST_M1, ST_MR, ST_M2, ST_MW, ST_END
	} dma4_state_t;
endpackage : dma4_pkg

// file: tb/dma4_bus_model.sv
`timescale 1ns/1ps
module dma4_bus_model #(
	parameter int ACK_DLY = 3
) (
	input wire logic i_clk,
	input wire logic i_hold_request,
	output logic o_hold_acknowledge,
	input wire logic [7:0] i_addr_lo,
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	input wire logic i_upper_address_strobe,
	input wire logic i_memory_read_strobe,
	input wire logic i_memory_write_strobe,
	output logic [7:0] o_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] hi_q;
	logic [7:0] last_q;
	int wait_q;
	initial
	begin
		o_hold_acknowledge = 1'b0;
		hi_q = 8'h00;
		last_q = 8'h00;
		wait_q = 0;
		foreach (mem[k])
			mem[k] = 8'h00;
	end
	// Undriven data shows the inverse of the last byte, never a stale match
	assign o_data = i_memory_read_strobe ? mem[{hi_q, i_addr_lo}] : ~last_q;
	// Processor yields the bus slowly, reclaims it at once
	always @(posedge i_clk)
	begin
		wait_q <= i_hold_request ? wait_q + 1 : 0;
		o_hold_acknowledge <= i_hold_request && wait_q >= ACK_DLY;
		if (i_upper_address_strobe && i_data_oe)
			hi_q <= i_data;
		if (i_memory_write_strobe && i_data_oe)
			mem[{hi_q, i_addr_lo}] <= i_data;
		if (i_memory_read_strobe)
			last_q <= o_data;
	end
endmodule : dma4_bus_model

// file: tb/dma4_core_checker.sv
`timescale 1ns/1ps
module dma4_core_checker (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_end_of_process_n,
	input wire logic o_hold_request,
	input wire logic [3:0] o_channel_acknowledge,
	input wire logic o_data_oe,
	input wire logic o_upper_address_strobe,
	input wire logic o_address_output_enable,
	input wire logic o_io_read_strobe,
	input wire logic o_io_write_strobe,
	input wire logic o_memory_read_strobe,
	input wire logic o_memory_write_strobe,
	input wire logic o_terminal_count
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	property p_io_in;
		o_io_read_strobe |-> !o_memory_read_strobe && !o_io_write_strobe;
	endproperty
	a_io_in: assert property (p_io_in)
		else $error("io read with bad strobe");
	property p_io_out;
		o_io_write_strobe |-> o_memory_read_strobe && !o_memory_write_strobe;
	endproperty
	a_io_out: assert property (p_io_out)
		else $error("io write without memory read");
	// Peripheral memory writes always pair with io read; pair mode never
	property p_no_ack;
		o_memory_write_strobe && !o_io_read_strobe |->
			o_channel_acknowledge == 4'h0;
	endproperty
	a_no_ack: assert property (p_no_ack)
		else $error("acknowledge in memory move");
	property p_keep_ack;
		$changed(o_channel_acknowledge) |->
			$past(o_channel_acknowledge) == 4'h0 || o_channel_acknowledge == 4'h0;
	endproperty
	a_keep_ack: assert property (p_keep_ack)
		else $error("service switched channel");
	property p_upper;
		o_upper_address_strobe |-> o_data_oe && o_address_output_enable
			##1 !o_upper_address_strobe;
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper address state malformed");
	property p_strobe_hold;
		o_io_read_strobe || o_io_write_strobe || o_memory_read_strobe ||
			o_memory_write_strobe |-> o_hold_request;
	endproperty
	a_strobe_hold: assert property (p_strobe_hold)
		else $error("strobe without hold");
	property p_hold_gap;
		$fell(o_hold_request) |=> !o_hold_request;
	endproperty
	a_hold_gap: assert property (p_hold_gap)
		else $error("hold not released");
	property p_tc_pulse;
		o_terminal_count |=> !o_terminal_count;
	endproperty
	a_tc_pulse: assert property (p_tc_pulse)
		else $error("terminal count too long");
	property p_eop_stop;
		$fell(i_end_of_process_n) && o_address_output_enable |->
			##[1:30] !o_hold_request;
	endproperty
	a_eop_stop: assert property (p_eop_stop)
		else $error("end of process ignored");
	c_move: cover property (o_memory_write_strobe && !o_io_read_strobe);
	c_tc: cover property (o_terminal_count);
	c_upper: cover property (o_upper_address_strobe);
endmodule : dma4_core_checker

bind dma4_core dma4_core_checker dma4_core_checker_i (
	.i_clk(i_clk), .i_srst(i_srst), .i_end_of_process_n(i_end_of_process_n),
	.o_hold_request(o_hold_request),
	.o_channel_acknowledge(o_channel_acknowledge), .o_data_oe(o_data_oe),
	.o_upper_address_strobe(o_upper_address_strobe),
	.o_address_output_enable(o_address_output_enable),
	.o_io_read_strobe(o_io_read_strobe), .o_io_write_strobe(o_io_write_strobe),
	.o_memory_read_strobe(o_memory_read_strobe),
	.o_memory_write_strobe(o_memory_write_strobe),
	.o_terminal_count(o_terminal_count)
);

// file: tb/test_four_channel_dma_transfer_core.sv
`timescale 1ns/1ps
module test_four_channel_dma_transfer_core;
	logic clk, srst, cs, wr, rd, eop_n, hold_request, hold_acknowledge, oe, stb, address_output_enable;
	logic io_read_strobe, io_write_strobe, mr, mw, tc, mw_p, up_p, mr_p, io_p;
	logic [3:0] ra, req, ack, ack_p;
	logic [7:0] wd, rdata, din, dout, alo, b;
	logic [15:0] v, ord, n_up, n_mw, n_mr, n_tc, n_io, n_aen;
	int n_mismatch, total_checks;
	dma4_core dma4_core_i (
		.i_clk(clk), .i_srst(srst), .i_reg_cs(cs), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(ra), .i_reg_wdata(wd), .o_reg_rdata(rdata),
		.i_channel_request(req), .i_hold_acknowledge(hold_acknowledge),
		.i_end_of_process_n(eop_n), .i_data(din), .o_hold_request(hold_request),
		.o_channel_acknowledge(ack), .o_addr_lo(alo), .o_data(dout),
		.o_data_oe(oe), .o_upper_address_strobe(stb),
		.o_address_output_enable(address_output_enable), .o_io_read_strobe(io_read_strobe),
		.o_io_write_strobe(io_write_strobe), .o_memory_read_strobe(mr),
		.o_memory_write_strobe(mw), .o_terminal_count(tc));
	dma4_bus_model dma4_bus_model_i (
		.i_clk(clk), .i_hold_request(hold_request), .o_hold_acknowledge(hold_acknowledge),
		.i_addr_lo(alo), .i_data(dout), .i_data_oe(oe),
		.i_upper_address_strobe(stb), .i_memory_read_strobe(mr),
		.i_memory_write_strobe(mw), .o_data(din));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Event tallies: acknowledge order, upper states, strobe pulses
	always @(posedge clk)
	begin
		for (int c = 0; c < 4; c++)
			if (ack[c] && !ack_p[c])
				ord <= {ord[11:0], 4'(c)};
		if (stb && !up_p)
			n_up <= n_up + 16'h0001;
		if (mw && !mw_p)
			n_mw <= n_mw + 16'h0001;
		if (mr && !mr_p)
			n_mr <= n_mr + 16'h0001;
		if ((io_read_strobe || io_write_strobe) && !io_p)
			n_io <= n_io + 16'h0001;
		if (tc)
			n_tc <= n_tc + 16'h0001;
		if (address_output_enable)
			n_aen <= n_aen + 16'h0001;
		ack_p <= ack;
		up_p <= stb;
		mw_p <= mw;
		mr_p <= mr;
		io_p <= io_read_strobe || io_write_strobe;
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		cs <= 1'b0;
		wr <= 1'b0;
	endtask : wr8
	task rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		rd <= 1'b1;
		ra <= a;
		@(posedge clk);
		cs <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rd8
	task wr16(input logic [3:0] a, input logic [15:0] d);
		wr8(a, d[7:0]);
		wr8(a, d[15:8]);
	endtask : wr16
	task rd16(input logic [3:0] a, output logic [15:0] d);
		rd8(a, d[7:0]);
		rd8(a, d[15:8]);
	endtask : rd16
	// A wait that ran out of cycles ends the run as a failure
	task limit(input logic ok);
		if (!ok)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask : limit
	// Idle means ten quiet cycles; the gap between services is shorter
	task serve();
		int q;
		q = 0;
		for (int i = 0; i < 100 && !hold_request; i++)
			@(posedge clk);
		limit(hold_request);
		for (int i = 0; i < 5000 && q < 10; i++)
		begin
			@(posedge clk);
			q = hold_request ? 0 : q + 1;
		end
		limit(q >= 10);
	endtask : serve
	task pulse(input logic [3:0] r);
		req <= r;
		for (int i = 0; i < 100 && ack == 4'h0; i++)
			@(posedge clk);
		limit(ack != 4'h0);
		req <= 4'h0;
		serve();
	endtask : pulse
	initial
	begin
		{srst, eop_n} = 2'b11;
		{cs, wr, rd, ra, wd, req} = '0;
		{ord, n_up, n_mw, n_mr, n_tc, n_io, n_aen} = '0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rd16(4'h0, v);
		chk(v, 16'h0000);
		wr16(4'h4, 16'h12FF);
		rd16(4'h4, v);
		chk(v, 16'h12FF);
		wr8(4'h5, 8'hAB);
		wr8(dma4_pkg::A_CLR_PTR, 8'h00);
		wr16(4'h5, 16'hEFCD);
		rd16(4'h5, v);
		chk(v, 16'hEFCD);
		$display("registers done");
		wr8(dma4_pkg::A_MASK_ALL, 8'h00);
		wr8(dma4_pkg::A_MODE, 8'h45);
		wr8(dma4_pkg::A_MODE, 8'h06);
		wr16(4'h2, 16'h0010);
		wr16(4'h3, 16'h0000);
		wr16(4'h5, 16'h0000);
		req <= 4'h6;
		serve();
		req <= 4'h0;
		chk(ord, 16'h0012);
		chk(n_mw, 16'h0002);
		chk(n_io, 16'h0002);
		chk(n_tc, 16'h0002);
		rd16(4'h2, v);
		chk(v, 16'h0011);
		rd16(4'h3, v);
		chk(v, 16'hFFFF);
		rd8(dma4_pkg::A_STATUS, b);
		chk({12'h000, b[3:0]}, 16'h0006);
		$display("fixed priority done");
		wr8(dma4_pkg::A_STATUS, 8'h10);
		wr8(dma4_pkg::A_MODE, 8'h44);
		wr8(dma4_pkg::A_MODE, 8'h41);
		wr16(4'h1, 16'h0001);
		wr16(4'h3, 16'h0001);
		wr8(dma4_pkg::A_MASK_ALL, 8'h00);
		{ord, n_mw, n_io} = '0;
		req <= 4'h3;
		serve();
		req <= 4'h0;
		chk(ord, 16'h0101);
		chk(n_mw, 16'h0002);
		chk(n_io, 16'h0002);
		$display("rotating done");
		wr8(dma4_pkg::A_STATUS, 8'h08);
		wr8(dma4_pkg::A_MODE, 8'hBB);
		wr16(4'h6, 16'h0100);
		wr16(4'h7, 16'h0001);
		wr8(dma4_pkg::A_MASK_ONE, 8'h03);
		{n_up, n_mr, n_io, n_tc, n_aen} = '0;
		pulse(4'h8);
		chk(n_up, 16'h0002);
		chk(n_mr, 16'h0002);
		chk(n_io, 16'h0002);
		chk(n_aen, 16'h0006);
		chk(n_tc, 16'h0001);
		rd16(4'h6, v);
		chk(v, 16'h0100);
		rd16(4'h7, v);
		chk(v, 16'h0001);
		ord = '0;
		pulse(4'h8);
		chk(ord, 16'h0003);
		$display("autoinit done");
		wr8(dma4_pkg::A_MASK_ALL, 8'h0F);
		wr8(dma4_pkg::A_STATUS, 8'h03);
		wr8(dma4_pkg::A_MODE, 8'h88);
		wr8(dma4_pkg::A_MODE, 8'h85);
		wr16(4'h0, 16'h0040);
		wr16(4'h1, 16'h0003);
		wr16(4'h2, 16'h0200);
		wr16(4'h3, 16'h0003);
		dma4_bus_model_i.mem[16'h0040] = 8'hA5;
		dma4_bus_model_i.mem[16'h0041] = 8'h5A;
		{ord, n_mw} = '0;
		wr8(dma4_pkg::A_REQUEST, 8'h04);
		serve();
		chk(n_mw, 16'h0004);
		for (int k = 0; k < 4; k++)
			chk({8'h00, dma4_bus_model_i.mem[512 + k]}, 16'h00A5);
		chk(ord, 16'h0000);
		rd16(4'h2, v);
		chk(v, 16'h0204);
		rd16(4'h3, v);
		chk(v, 16'hFFFF);
		rd16(4'h0, v);
		chk(v, 16'h0040);
		rd8(dma4_pkg::A_TEMP_CLR, b);
		chk({8'h00, b}, 16'h00A5);
		$display("memory move done");
		wr8(dma4_pkg::A_STATUS, 8'h01);
		wr16(4'h1, 16'h00FF);
		wr16(4'h2, 16'h0300);
		wr16(4'h3, 16'h00FF);
		n_mw = '0;
		wr8(dma4_pkg::A_REQUEST, 8'h04);
		for (int i = 0; i < 500 && n_mw < 16'h0003; i++)
			@(posedge clk);
		limit(n_mw >= 16'h0003);
		eop_n <= 1'b0;
		for (int i = 0; i < 100 && hold_request; i++)
			@(posedge clk);
		limit(!hold_request);
		eop_n <= 1'b1;
		repeat (12) @(posedge clk);
		chk({15'h0000, hold_request}, 16'h0000);
		chk({15'h0000, n_mw < 16'h0014}, 16'h0001);
		$display("end of process done");
		end_of_test();
	end
endmodule : test_four_channel_dma_transfer_core
